// ==== pkg/spr_pkg.sv ====
package spr_pkg;

    // Serial command codes, shifted in least significant bit first
    localparam logic [3:0] CMD_CORE_INSTR = 4'h0;
    localparam logic [3:0] CMD_SHIFT_DATA = 4'h2;
    localparam logic [3:0] CMD_TBL_RD_INC = 4'h9;

    // Link framing: command bits, operand bits, first-half length
    localparam logic [3:0] CMD_LAST_BIT = 4'h3;
    localparam logic [3:0] OPER_LAST_BIT = 4'hF;
    localparam logic [3:0] OPER_HALF = 4'h8;

    // Address map
    localparam logic [23:0] CFG_BASE = 24'h300000;
    localparam logic [3:0] CFG_LAST_IDX = 4'hD;
    localparam logic [3:0] CFG_LOWV_IDX = 4'h6;
    localparam int LOWV_BIT = 2;
    localparam logic [23:0] DEVID_LO_ADDR = 24'h3FFFFE;
    localparam logic [23:0] DEVID_HI_ADDR = 24'h3FFFFF;

    // Values after reset and fixed read values
    localparam logic [23:0] PTR_RESET = 24'h000000;
    localparam logic LOWV_RESET = 1'b1;
    localparam logic [7:0] PROTECTED_BYTE = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // Request carried from the link side to the system side
    typedef struct packed {
        logic [3:0] cmd;
        logic [15:0] word;
    } spr_req_t;

    // Implemented bits of each configuration byte; the rest read zero
    function automatic logic [7:0] cfg_mask(input logic [3:0] idx);
        unique case (idx)
            4'h1: return 8'h2F;
            4'h2: return 8'h0F;
            4'h3: return 8'h1F;
            4'h4: return 8'h83;
            4'h5: return 8'h83;
            4'h6: return 8'h85;
            4'h8: return 8'h0F;
            4'h9: return 8'hC0;
            4'hA: return 8'h0F;
            4'hB: return 8'hE0;
            4'hC: return 8'h0F;
            4'hD: return 8'h40;
            default: return 8'h00;
        endcase
    endfunction : cfg_mask

endpackage : spr_pkg

// ==== hw/spr_sync.sv ====
`timescale 1ns/1ns
module spr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    // Power-up value keeps the far domain defined before any reset reaches it
    logic [WIDTH-1:0] meta_reg = '0;
    logic [WIDTH-1:0] q_reg = '0;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= d_i;
            q_reg <= meta_reg;
        end
    end

    assign q_o = q_reg;

endmodule : spr_sync

// ==== hw/spr_readback.sv ====
`timescale 1ns/1ns
// How it works
// RL1: Command 1001 returns one byte per issue
// RL2: Pointed byte goes to latch, then pin
// RL3: Command bits arrive LSB first, one per clock
// RL4: Access in first eight, shift out last eight
// RL5: Pin turns to output after eighth operand clock
// RL6: Each table read advances pointer by one
// RL7: Reads reach the full 24-bit space
// RL8: Top code address wraps pointer to zero
// RL9: Programmer reloads pointer for ID area
// RL10: Programmer pairs two bytes per code word
// RL11: Configuration bytes compared singly
// RL12: EEPROM read fills the data-holding latch
// RL13: Command 0010 shifts out the data latch
// RL14: Low output byte undefined, high carries data
// RL15: Command 0000 injects core instructions
// RL16: Erased cells read as ones
// RL17: Reserved configuration bits read zero
// RL18: Blank check skips the device ID bytes
// RL19: ID and config bytes ignore protection
// RL20: Configuration written last; ID nibble advice
// RL21: Low-voltage enable powers up as one
// RL22: Cleared enable frees mode pin, blocks low-voltage
// RL23: High-voltage entry always works
module spr_readback
    import spr_pkg::*;
#(
    parameter int CODE_BYTES = 65536,
    parameter logic [7:0] DEVID_LOW = 8'hA5,
    parameter logic [7:0] DEVID_HIGH = 8'h5A
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic prog_clk_i,
    input wire logic prog_data_pin_i,
    output logic prog_data_pin_o,
    output logic prog_data_pin_oe_n_o,
    input wire logic master_clear_hv_i,
    input wire logic mode_select_pin_i,
    output logic mode_select_gpio_en_o,
    output logic prog_mode_o,
    output logic low_voltage_enable_o,
    input wire logic lowv_write_i,
    input wire logic lowv_wdata_i,
    input wire logic code_protect_i,
    output logic mem_rd_o,
    output logic [23:0] mem_addr_o,
    input wire logic [7:0] mem_rdata_i,
    input wire logic tblptr_load_i,
    input wire logic [23:0] tblptr_data_i,
    output logic [23:0] table_pointer_o,
    input wire logic ee_read_i,
    input wire logic [15:0] ee_addr_i,
    output logic ee_rd_o,
    output logic [15:0] ee_addr_o,
    input wire logic [7:0] ee_rdata_i,
    output logic [7:0] eeprom_data_latch_o,
    output logic [15:0] core_instr_o,
    output logic core_instr_valid_o
);
    import spr_pkg::*;

    if (CODE_BYTES < 256 || CODE_BYTES > 24'h200000) begin : g_chk
        $error("CODE_BYTES must lie between 256 and the ID area base");
    end

    localparam logic [23:0] CODE_TOP = 24'(CODE_BYTES - 1);

    typedef enum logic {L_CMD, L_OPER} spr_lstate_t;
    typedef enum logic {S_IDLE, S_CAP} spr_sstate_t;

    function automatic logic is_read_cmd(input logic [3:0] c);
        return (c == CMD_TBL_RD_INC) || (c == CMD_SHIFT_DATA);
    endfunction : is_read_cmd

    function automatic logic is_cfg(input logic [23:0] a);
        return (a[23:4] == CFG_BASE[23:4]) && (a[3:0] <= CFG_LAST_IDX);
    endfunction : is_cfg

    // RL19 protection spares ID
    // Protection only hides code space; ID, config and device ID read true
    function automatic logic [7:0] read_filter(input logic [23:0] a, input logic [7:0] d,
                                               input logic prot, input logic lowv);
        logic [7:0] b;
        b = d;
        if (a <= CODE_TOP) begin
            b = prot ? PROTECTED_BYTE : d;
        end else if (a == DEVID_LO_ADDR) begin
            b = DEVID_LOW;
        end else if (a == DEVID_HI_ADDR) begin
            b = DEVID_HIGH;
        end else if (is_cfg(a)) begin
            b = d & cfg_mask(a[3:0]);
            if (a[3:0] == CFG_LOWV_IDX) begin
                b[LOWV_BIT] = lowv;
            end
        end
        return b;
    endfunction : read_filter

    // Wrap only at the top of code space; elsewhere the full 24 bits count
    function automatic logic [23:0] ptr_next(input logic [23:0] p);
        return (p == CODE_TOP) ? PTR_RESET : p + 24'h000001;
    endfunction : ptr_next

    // ---------------- System domain ----------------
    logic hv_sync;
    logic msel_sync;
    logic req_sync;
    logic prog_mode_reg;
    logic lowv_reg;
    logic gpio_en_reg;
    logic req_seen_reg;
    logic req_new;
    logic ack_tgl_reg;
    logic [7:0] ack_byte_reg;
    logic [23:0] tblptr_reg;
    logic mem_rd_reg;
    logic [23:0] mem_addr_reg;
    logic ee_rd_reg;
    logic [15:0] ee_addr_reg;
    logic [7:0] ee_latch_reg;
    logic [15:0] core_instr_reg;
    logic core_valid_reg;
    spr_sstate_t sstate_reg;

    // Link side, declared here because the system side reads it
    logic req_tgl_reg;
    spr_req_t req_reg;

    spr_sync #(.WIDTH(3)) u_sync_sys (
        .clk_i(clk_sys_i),
        .reset_i(reset_i),
        .d_i({master_clear_hv_i, mode_select_pin_i, req_tgl_reg}),
        .q_o({hv_sync, msel_sync, req_sync})
    );

    assign req_new = prog_mode_reg && (req_sync != req_seen_reg);

    // RL23 high-voltage entry
    // RL22 low-voltage entry gated
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            prog_mode_reg <= 1'b0;
        end else begin
            prog_mode_reg <= hv_sync || (lowv_reg && msel_sync);
        end
    end

    // RL21 factory value one
    // RL23 changed only under high voltage
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            lowv_reg <= LOWV_RESET;
        end else if (lowv_write_i && hv_sync) begin
            lowv_reg <= lowv_wdata_i;
        end
    end

    // RL22 mode pin released
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            gpio_en_reg <= 1'b0;
        end else begin
            gpio_en_reg <= !lowv_reg;
        end
    end

    // RL6 pointer advance
    // RL8 code space wrap
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            tblptr_reg <= PTR_RESET;
        end else if (tblptr_load_i) begin
            tblptr_reg <= tblptr_data_i;
        end else if (sstate_reg == S_CAP) begin
            tblptr_reg <= ptr_next(tblptr_reg);
        end
    end

    // RL12 EEPROM into latch
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ee_rd_reg <= 1'b0;
            ee_addr_reg <= 16'h0000;
            ee_latch_reg <= BYTE_RESET;
        end else begin
            ee_rd_reg <= ee_read_i;
            if (ee_read_i) begin
                ee_addr_reg <= ee_addr_i;
            end
            if (ee_rd_reg) begin
                ee_latch_reg <= ee_rdata_i;
            end
        end
    end

    // Requests from the link; the payload is stable once the toggle is seen
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            sstate_reg <= S_IDLE;
            req_seen_reg <= 1'b0;
            ack_tgl_reg <= 1'b0;
            ack_byte_reg <= BYTE_RESET;
            mem_rd_reg <= 1'b0;
            mem_addr_reg <= PTR_RESET;
            core_instr_reg <= 16'h0000;
            core_valid_reg <= 1'b0;
        end else begin
            mem_rd_reg <= 1'b0;
            core_valid_reg <= 1'b0;
            if (!prog_mode_reg) begin
                req_seen_reg <= req_sync;
            end
            unique case (sstate_reg)
                S_IDLE: begin
                    if (req_new) begin
                        req_seen_reg <= req_sync;
                        // RL7 full address reach
                        // RL2 pointed byte fetched
                        if (req_reg.cmd == CMD_TBL_RD_INC) begin
                            mem_rd_reg <= 1'b1;
                            mem_addr_reg <= tblptr_reg;
                            sstate_reg <= S_CAP;
                        end else if (req_reg.cmd == CMD_SHIFT_DATA) begin
                            // RL13 data latch out
                            ack_byte_reg <= ee_latch_reg;
                            ack_tgl_reg <= !ack_tgl_reg;
                        end else if (req_reg.cmd == CMD_CORE_INSTR) begin
                            // RL15 core instruction
                            core_instr_reg <= req_reg.word;
                            core_valid_reg <= 1'b1;
                        end
                    end
                end
                S_CAP: begin
                    // RL16 erased reads ones
                    // RL17 reserved bits zero
                    ack_byte_reg <= read_filter(mem_addr_reg, mem_rdata_i, code_protect_i,
                                                lowv_reg);
                    ack_tgl_reg <= !ack_tgl_reg;
                    sstate_reg <= S_IDLE;
                end
            endcase
        end
    end

    assign prog_mode_o = prog_mode_reg;
    assign low_voltage_enable_o = lowv_reg;
    assign mode_select_gpio_en_o = gpio_en_reg;
    assign table_pointer_o = tblptr_reg;
    assign mem_rd_o = mem_rd_reg;
    assign mem_addr_o = mem_addr_reg;
    assign ee_rd_o = ee_rd_reg;
    assign ee_addr_o = ee_addr_reg;
    assign eeprom_data_latch_o = ee_latch_reg;
    assign core_instr_o = core_instr_reg;
    assign core_instr_valid_o = core_valid_reg;

    // ---------------- Link domain ----------------
    logic mode_link;
    logic ack_sync;
    logic link_rst;
    spr_lstate_t lstate_reg;
    logic [3:0] cnt_reg;
    logic [3:0] cmd_reg;
    logic [3:0] cmd_next;
    logic [15:0] oper_reg;
    logic ack_seen_reg;
    logic [7:0] byte_reg;
    logic [7:0] out_sh_reg;
    logic dout_reg;
    logic oe_n_reg;
    logic drive_win;

    spr_sync #(.WIDTH(2)) u_sync_link (
        .clk_i(prog_clk_i),
        .reset_i(1'b0),
        .d_i({prog_mode_reg, ack_tgl_reg}),
        .q_o({mode_link, ack_sync})
    );

    // Leaving programming mode is the link side's only reset
    assign link_rst = !mode_link;
    assign cmd_next = {prog_data_pin_i, cmd_reg[3:1]};
    assign drive_win = (lstate_reg == L_OPER) && is_read_cmd(cmd_reg) && (cnt_reg >= OPER_HALF);

    always_ff @(posedge prog_clk_i) begin
        if (link_rst) begin
            lstate_reg <= L_CMD;
            cnt_reg <= 4'h0;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
            unique case (lstate_reg)
                L_CMD: begin
                    if (cnt_reg == CMD_LAST_BIT) begin
                        lstate_reg <= L_OPER;
                        cnt_reg <= 4'h0;
                    end
                end
                L_OPER: begin
                    if (cnt_reg == OPER_LAST_BIT) begin
                        lstate_reg <= L_CMD;
                        cnt_reg <= 4'h0;
                    end
                end
            endcase
        end
    end

    // RL3 LSB-first shifting
    always_ff @(posedge prog_clk_i) begin
        if (link_rst) begin
            cmd_reg <= 4'h0;
            oper_reg <= 16'h0000;
        end else if (lstate_reg == L_CMD) begin
            cmd_reg <= cmd_next;
        end else begin
            oper_reg <= {prog_data_pin_i, oper_reg[15:1]};
        end
    end

    // RL1 one fetch per command
    // RL15 operand handed over whole
    always_ff @(posedge prog_clk_i) begin
        if (link_rst) begin
            req_tgl_reg <= 1'b0;
            req_reg <= '0;
        end else if (lstate_reg == L_CMD && cnt_reg == CMD_LAST_BIT
                     && is_read_cmd(cmd_next)) begin
            req_reg <= '{cmd: cmd_next, word: 16'h0000};
            req_tgl_reg <= !req_tgl_reg;
        end else if (lstate_reg == L_OPER && cnt_reg == OPER_LAST_BIT
                     && cmd_reg == CMD_CORE_INSTR) begin
            req_reg <= '{cmd: CMD_CORE_INSTR, word: {prog_data_pin_i, oper_reg[15:1]}};
            req_tgl_reg <= !req_tgl_reg;
        end
    end

    // Answer must land within the first eight operand clocks
    always_ff @(posedge prog_clk_i) begin
        if (link_rst) begin
            ack_seen_reg <= ack_sync;
            byte_reg <= BYTE_RESET;
        end else if (ack_sync != ack_seen_reg) begin
            ack_seen_reg <= ack_sync;
            byte_reg <= ack_sync ? ack_byte_reg : ack_byte_reg;
        end
    end

    // RL5 turnaround at falling edge
    // RL4 last eight, LSB first
    // RL14 first half stays input
    always_ff @(negedge prog_clk_i) begin
        if (link_rst) begin
            oe_n_reg <= 1'b1;
            dout_reg <= 1'b0;
            out_sh_reg <= BYTE_RESET;
        end else begin
            oe_n_reg <= !drive_win;
            if (drive_win && cnt_reg == OPER_HALF) begin
                dout_reg <= byte_reg[0];
                out_sh_reg <= {1'b0, byte_reg[7:1]};
            end else begin
                dout_reg <= out_sh_reg[0];
                out_sh_reg <= {1'b0, out_sh_reg[7:1]};
            end
        end
    end

    assign prog_data_pin_o = dout_reg;
    assign prog_data_pin_oe_n_o = oe_n_reg;

    // ---------------- Checks ----------------

    sequence s_drive_byte;
        !prog_data_pin_oe_n_o [*8];
    endsequence

    sequence s_release;
        prog_data_pin_oe_n_o;
    endsequence

    a_ptr_advance: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RL6
        (sstate_reg == S_CAP && !tblptr_load_i && tblptr_reg != CODE_TOP)
        |=> tblptr_reg == $past(tblptr_reg) + 24'h000001)
        else $error("table pointer did not advance by one");

    a_ptr_wrap: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RL8
        (sstate_reg == S_CAP && !tblptr_load_i && tblptr_reg == CODE_TOP)
        |=> tblptr_reg == PTR_RESET)
        else $error("table pointer did not wrap at code top");

    a_blank_ones: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RL16
        (sstate_reg == S_CAP && mem_addr_reg <= CODE_TOP && !code_protect_i
         && mem_rdata_i == 8'hFF) |=> ack_byte_reg == 8'hFF)
        else $error("erased code byte not read as ones");

    a_cfg_reserved: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RL17
        (sstate_reg == S_CAP && is_cfg(mem_addr_reg))
        |=> (ack_byte_reg & ~cfg_mask(mem_addr_reg[3:0])) == 8'h00)
        else $error("reserved configuration bit read as one");

    a_devid_true: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RL19
        (sstate_reg == S_CAP && mem_addr_reg == DEVID_LO_ADDR)
        |=> ack_byte_reg == DEVID_LOW)
        else $error("device ID byte not read back");

    a_lowv_powerup: assert property ( // RL21
        @(posedge clk_sys_i) reset_i |=> lowv_reg)
        else $error("low-voltage enable not one after reset");

    a_lowv_blocked: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RL22
        (!lowv_reg && !hv_sync) |=> !prog_mode_reg)
        else $error("low-voltage entry taken while disabled");

    a_hv_entry: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RL23
        hv_sync |=> prog_mode_reg)
        else $error("high-voltage entry refused");

    a_lowv_hv_only: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RL23
        !hv_sync |=> lowv_reg == $past(lowv_reg))
        else $error("low-voltage enable changed without high voltage");

    a_ee_latch: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RL12
        (ee_read_i ##1 !ee_read_i) |=> ee_latch_reg == $past(ee_rdata_i))
        else $error("EEPROM byte not placed in latch");

    a_shift_latch: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RL13
        (sstate_reg == S_IDLE && req_new && req_reg.cmd == CMD_SHIFT_DATA)
        |=> ack_byte_reg == $past(ee_latch_reg))
        else $error("shift-out did not take the data latch");

    a_req_on_read: assert property ( // RL1
        @(posedge prog_clk_i) disable iff (link_rst)
        (lstate_reg == L_CMD && cnt_reg == CMD_LAST_BIT && is_read_cmd(cmd_next))
        |=> req_tgl_reg != $past(req_tgl_reg))
        else $error("read command raised no fetch");

    a_cmd_lsb_first: assert property ( // RL3
        @(posedge prog_clk_i) disable iff (link_rst)
        (lstate_reg == L_CMD && cnt_reg == CMD_LAST_BIT)
        |=> cmd_reg[3] == $past(prog_data_pin_i) && cmd_reg[0] == $past(prog_data_pin_i, 4))
        else $error("command bits not shifted LSB first");

    a_drive_window: assert property ( // RL4
        @(negedge prog_clk_i) disable iff (link_rst)
        (lstate_reg == L_OPER && is_read_cmd(cmd_reg) && cnt_reg == OPER_HALF)
        |=> s_drive_byte ##1 s_release)
        else $error("data pin not driven for exactly eight clocks");

endmodule : spr_readback

// ==== verif/spr_prog_model.sv ====
`timescale 1ns/1ns
module spr_prog_model #(
    parameter int HALF_NS = 15,
    parameter int TURN_NS = 60
) (
    input wire logic pin_i,
    output logic clk_o,
    output logic d_o,
    output logic [7:0] rx_byte_o,
    output logic rx_valid_o
);
    logic drive;

    initial begin
        clk_o = 1'b0;
        d_o = 1'b0;
        drive = 1'b1;
        rx_byte_o = 8'h00;
        rx_valid_o = 1'b0;
    end

    // Released line toggles so a stale level is never read as data
    task automatic tick(input logic b, output logic s);
        d_o = drive ? b : ~d_o;
        #HALF_NS clk_o = 1'b1;
        s = pin_i;
        #HALF_NS clk_o = 1'b0;
    endtask : tick

    // Two ignored edges while the link leaves reset
    task automatic start();
        logic s;
        repeat (2) tick(1'b0, s);
    endtask : start

    task automatic frame(input logic [3:0] cmd, input logic [15:0] word, input logic rd);
        logic s;
        for (int i = 0; i < 4; i++) tick(cmd[i], s);
        for (int i = 0; i < 16; i++) begin
            if (rd && i == 8) begin
                // clock held low while the pin turns
                drive = 1'b0;
                #TURN_NS;
            end
            tick(word[i], s);
            // byte arrives LSB first in the last eight clocks
            if (i >= 8) rx_byte_o[i-8] = s;
        end
        drive = 1'b1;
        if (rd) begin
            rx_valid_o = 1'b1;
            #1 rx_valid_o = 1'b0;
        end
    endtask : frame
endmodule : spr_prog_model

// ==== verif/test_spr_readback.sv ====
`timescale 1ns/1ns
module test_spr_readback;
    import spr_pkg::*;
    localparam logic [7:0] DEV_LO = 8'h3C; // arbitrary value
    localparam logic [7:0] DEV_HI = 8'hC3; // arbitrary value
    logic clk_sys_i, reset_i, msel, hv, lv_wr, lv_wd, cprot, tb_ld, ee_req, blank;
    logic [23:0] tb_ptr, mem_addr, tptr;
    logic [15:0] ee_a, ee_addr, core_w, w;
    logic [7:0] key, ee_key, latch, rx_byte, e;
    logic pclk, pd, pin, dout, oe_n, gpio_en, pmode, lowv, mem_rd, ee_rd, core_v, rx_v;
    logic [31:0] seed_val;
    logic [7:0] exp_b[$];
    logic [15:0] exp_w[$];
    int err_total, tests_run;

    assign pin = (oe_n === 1'b0) ? dout : pd;

    spr_readback #(.DEVID_LOW(DEV_LO), .DEVID_HIGH(DEV_HI)) u_dut (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .prog_clk_i(pclk),
        .prog_data_pin_i(pin), .prog_data_pin_o(dout), .prog_data_pin_oe_n_o(oe_n),
        .master_clear_hv_i(hv), .mode_select_pin_i(msel),
        .mode_select_gpio_en_o(gpio_en), .prog_mode_o(pmode), .low_voltage_enable_o(lowv),
        .lowv_write_i(lv_wr), .lowv_wdata_i(lv_wd), .code_protect_i(cprot),
        .mem_rd_o(mem_rd), .mem_addr_o(mem_addr),
        .mem_rdata_i((mem_rd === 1'b1) ? (blank ? 8'hFF : exp_mem(mem_addr)) : 8'h00),
        .tblptr_load_i(tb_ld), .tblptr_data_i(tb_ptr), .table_pointer_o(tptr),
        .ee_read_i(ee_req), .ee_addr_i(ee_a), .ee_rd_o(ee_rd), .ee_addr_o(ee_addr),
        .ee_rdata_i((ee_rd === 1'b1) ? ee_addr[7:0] ^ ee_key : ~(ee_addr[7:0] ^ ee_key)),
        .eeprom_data_latch_o(latch),
        .core_instr_o(core_w), .core_instr_valid_o(core_v)
    );

    spr_prog_model u_prog (
        .pin_i(pin), .clk_o(pclk), .d_o(pd), .rx_byte_o(rx_byte), .rx_valid_o(rx_v)
    );

    function automatic logic [7:0] exp_mem(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ key;
    endfunction : exp_mem

    task automatic chk_byte(input string nm, input logic [7:0] ex, input logic [7:0] g);
        tests_run++;
        if (g !== ex) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, ex, g);
        end
    endtask : chk_byte

    task automatic chk_val(input string nm, input logic [23:0] ex, input logic [23:0] g);
        tests_run++;
        if (g !== ex) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, ex, g);
        end
    endtask : chk_val

    task automatic close_out();
        if (exp_b.size() != 0 || exp_w.size() != 0) err_total++;
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask : cyc

    task automatic rd_next(input logic [7:0] ex);
        exp_b.push_back(ex);
        u_prog.frame(CMD_TBL_RD_INC, 16'h0000, 1'b1);
        cyc(12);
    endtask : rd_next

    task automatic rd_at(input logic [23:0] a, input logic [7:0] ex);
        cyc(1);
        tb_ld = 1'b1;
        tb_ptr = a;
        cyc(1);
        tb_ld = 1'b0;
        cyc(4);
        rd_next(ex);
    endtask : rd_at

    task automatic lv_pulse(input logic v);
        cyc(1);
        lv_wr = 1'b1;
        lv_wd = v;
        cyc(1);
        lv_wr = 1'b0;
        cyc(8);
    endtask : lv_pulse

    always @(posedge rx_v) begin
        chk_byte("link byte", exp_b.size() ? exp_b.pop_front() : 8'hXX, rx_byte);
    end

    always @(negedge clk_sys_i) begin
        if (core_v === 1'b1) chk_val("core word", exp_w.size() ? exp_w.pop_front() : 16'hXXXX,
                                     core_w);
    end

    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        #1000000;
        err_total++;
        close_out();
    end

    initial begin
        {msel, hv, lv_wr, lv_wd, cprot, tb_ld, ee_req, blank} = 8'h00;
        tb_ptr = 24'h000000;
        ee_a = 16'h0000;
        err_total = 0;
        tests_run = 0;
        reset_i = 1'b1;
        seed_val = $urandom(32'h5A4C44E0);
        key = 8'($urandom);
        ee_key = 8'($urandom);
        cyc(4);
        reset_i = 1'b0;
        cyc(1);
        chk_val("lowv reset", 24'h1, {23'h0, lowv});
        chk_val("pointer reset", PTR_RESET, tptr);
        lv_pulse(1'b0);
        chk_val("lowv no hv", 24'h1, {23'h0, lowv});
        hv = 1'b1;
        for (int i = 0; i < 100 && pmode !== 1'b1; i++) cyc(1);
        chk_val("prog mode", 24'h1, {23'h0, pmode});
        if (pmode !== 1'b1) close_out();
        #200;
        u_prog.start();
        // two bytes of one word read back to back
        rd_at(24'h00FFFE, exp_mem(24'h00FFFE));
        chk_val("pointer step", 24'h00FFFF, tptr);
        rd_next(exp_mem(24'h00FFFF));
        chk_val("pointer wrap", 24'h000000, tptr);
        $display("test wrap done");
        rd_at(24'h200000, exp_mem(24'h200000));
        rd_at(24'h300006, (exp_mem(24'h300006) & 8'h81) | 8'h04);
        $display("test config done");
        cprot = 1'b1;
        rd_at(24'h000010, PROTECTED_BYTE);
        rd_at(24'h200003, exp_mem(24'h200003));
        rd_at(DEVID_LO_ADDR, DEV_LO);
        rd_next(DEV_HI);
        cprot = 1'b0;
        $display("test protect done");
        blank = 1'b1;
        // device id bytes left out of the blank pass
        rd_at(24'h001234, 8'hFF);
        rd_at(24'h200005, 8'hFF);
        rd_at(24'h300001, 8'h2F);
        blank = 1'b0;
        $display("test blank done");
        ee_a = 16'($urandom);
        e = ee_a[7:0] ^ ee_key;
        ee_req = 1'b1;
        cyc(1);
        ee_req = 1'b0;
        cyc(4);
        chk_byte("eeprom latch", e, latch);
        exp_b.push_back(e);
        u_prog.frame(CMD_SHIFT_DATA, 16'h0000, 1'b1);
        cyc(12);
        $display("test eeprom done");
        w = 16'($urandom);
        exp_w.push_back(w);
        u_prog.frame(CMD_CORE_INSTR, w, 1'b0);
        cyc(20);
        $display("test core done");
        lv_pulse(1'b0);
        chk_val("lowv cleared", 24'h0, {23'h0, lowv});
        chk_val("gpio free", 24'h1, {23'h0, gpio_en});
        chk_val("mode kept", 24'h1, {23'h0, pmode});
        rd_at(24'h300006, exp_mem(24'h300006) & 8'h81);
        hv = 1'b0;
        msel = 1'b1;
        cyc(10);
        chk_val("lowv entry refused", 24'h0, {23'h0, pmode});
        $display("test lowv done");
        close_out();
    end
endmodule : test_spr_readback
